// [rtl/sfc_counter.sv]
// four-bit synchronous presettable counter, decade or binary, async or sync clear
//
// Functional notes
// [RL1] count held in four flops, load replaces whole count with preload value
// [RL2] count changes only on rising clock, except asynchronous clear
// [RL3] decade variant counts bcd modulo 10, nine wraps to zero
// [RL4] binary variant counts modulo 16, fifteen wraps to zero
// [RL5] decade flag high when trickle enable high and count nine
// [RL6] binary flag high when trickle enable high and count fifteen
// [RL7] flag fully decoded, asserted for exactly one count state
// [RL8] decade illegal states return to legal sequence within two counts
// [RL9] decade flag stays low for states ten to fifteen
// [RL10] count up only when load inactive and both enables high
// [RL11] load low copies preload regardless of count enables
// [RL12] either enable low with load inactive holds the count
// [RL13] counting gated by and of both enables for cascading
// [RL14] async clear low immediately forces count low, overrides all
// [RL15] sync clear low clears at next edge, beats load and count
// [RL16] surrounding logic must hold unused async clear high
// [RL17] parameters select modulo 10 or 16 and async or sync clear
// [RL18] decade illegal: 10 to 11 to 6, 12 to 13 to 4, 14 to 15 to 2
// [RL19] cascade by feeding flag to next trickle enable, share parallel enables
`timescale 1ns/1ns
module sfc_counter #(
  parameter bit DECADE = 1'b1, // RL17 1: modulo 10, 0: modulo 16
  parameter bit ASYNC_CLEAR = 1'b1 // RL17 1: async clear, 0: clear on clock edge
) (
  input wire logic core_clk_in, // rising edge clock
  input wire logic rstn_in, // synchronous reset, active low
  input wire logic load_enable_n_in, // load, active low
  input wire logic parallel_count_enable_in, // parallel count enable
  input wire logic trickle_count_enable_in, // trickle count enable
  input wire logic async_clear_n_in, // async clear pin, active low
  input wire logic sync_clear_n_in, // synchronous clear, active low
  input wire logic [3:0] preload_value_in, // parallel load value
  output logic [3:0] count_value_out, // count
  output logic terminal_count_flag_out // terminal count, combinational
);
  logic [3:0] count_reg;
  logic [3:0] count_next;
  logic clear_sync;
  logic count_en;
  logic [3:0] last_state;
  logic clear_idle;

  // increment; decade walks the odd illegal states back into the legal range
  function automatic logic [3:0] step(input logic [3:0] cur);
    logic [3:0] nxt;
    nxt = cur + 4'h1; // RL4
    if (DECADE) begin
      if (cur == sfc_pkg::DECADE_LAST) begin
        nxt = sfc_pkg::COUNT_RESET; // RL3
      end else if (cur == 4'hb) begin
        nxt = 4'h6; // RL18 RL8
      end else if (cur == 4'hd) begin
        nxt = 4'h4; // RL18 RL8
      end else if (cur == 4'hf) begin
        nxt = 4'h2; // RL18 RL8
      end
    end
    return nxt;
  endfunction

  // async clear pin is brought into the core domain
  sfc_sync2 #(.RESET_VAL(1'b1)) u_clr_sync (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .async_in(async_clear_n_in),
    .sync_out(clear_sync)
  );

  assign count_en = load_enable_n_in & parallel_count_enable_in & trickle_count_enable_in; // RL13 RL10

  // clear inactive as the count flops see it, used by the checks
  assign clear_idle = ASYNC_CLEAR ? clear_sync : sync_clear_n_in;

  // next count, clear first then load then count
  always_comb begin
    count_next = count_reg;
    if (!ASYNC_CLEAR && !sync_clear_n_in) begin
      count_next = sfc_pkg::COUNT_RESET; // RL15
    end else if (!load_enable_n_in) begin
      count_next = preload_value_in; // RL11 RL1
    end else if (count_en) begin
      count_next = step(count_reg); // RL10
    end
  end

  // count flops, one update per rising edge
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      count_reg <= sfc_pkg::COUNT_RESET;
    end else if (ASYNC_CLEAR && !clear_sync) begin
      count_reg <= sfc_pkg::COUNT_RESET; // RL14
    end else begin
      count_reg <= count_next; // RL2 RL12
    end
  end

  // async variant forces outputs low while clear pin is low
  assign count_value_out = (ASYNC_CLEAR && !async_clear_n_in) ? sfc_pkg::COUNT_RESET : count_reg; // RL14 RL16

  assign last_state = DECADE ? sfc_pkg::DECADE_LAST : sfc_pkg::BINARY_LAST;
  // flag fully decoded on the one terminal state
  assign terminal_count_flag_out = trickle_count_enable_in && (count_value_out == last_state); // RL5 RL6 RL7 RL9 RL19

  // assertions
  // load copies the preload value
  property p_load;
    @(posedge core_clk_in) disable iff (!rstn_in)
    (load_enable_n_in == 1'b0 && (ASYNC_CLEAR || sync_clear_n_in) && (!ASYNC_CLEAR || clear_sync))
      |=> count_reg == $past(preload_value_in);
  endproperty
  a_load: assert property (p_load) else $error("load did not copy preload"); // RL11

  // either enable low holds the count
  property p_hold;
    @(posedge core_clk_in) disable iff (!rstn_in)
    (load_enable_n_in && !(parallel_count_enable_in && trickle_count_enable_in)
      && (ASYNC_CLEAR || sync_clear_n_in) && (!ASYNC_CLEAR || clear_sync)) |=> $stable(count_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("count changed while disabled"); // RL12

  // terminal state wraps to zero
  property p_wrap;
    @(posedge core_clk_in) disable iff (!rstn_in)
    (count_en && count_reg == last_state && (ASYNC_CLEAR || sync_clear_n_in) && (!ASYNC_CLEAR || clear_sync))
      |=> count_reg == 4'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("terminal state did not wrap"); // RL3

  // low legal states step by one
  property p_inc;
    @(posedge core_clk_in) disable iff (!rstn_in)
    (count_en && count_reg < 4'h9 && (ASYNC_CLEAR || sync_clear_n_in) && (!ASYNC_CLEAR || clear_sync))
      |=> count_reg == $past(count_reg) + 4'h1;
  endproperty
  a_inc: assert property (p_inc) else $error("count did not step by one"); // RL10

  // synchronous clear empties the count at the edge
  property p_sclr;
    @(posedge core_clk_in) disable iff (!rstn_in)
    (!ASYNC_CLEAR && !sync_clear_n_in) |=> count_reg == 4'h0;
  endproperty
  a_sclr: assert property (p_sclr) else $error("sync clear missed"); // RL15

  // clear pin forces outputs low at once
  property p_aclr;
    @(posedge core_clk_in) disable iff (!rstn_in)
    (ASYNC_CLEAR && !async_clear_n_in) |-> count_value_out == 4'h0 && !terminal_count_flag_out;
  endproperty
  a_aclr: assert property (p_aclr) else $error("async clear not forcing low"); // RL14

  // flag only on the one terminal state
  property p_flag;
    @(posedge core_clk_in) disable iff (!rstn_in)
    terminal_count_flag_out |-> trickle_count_enable_in && count_value_out == (DECADE ? 4'h9 : 4'hf);
  endproperty
  a_flag: assert property (p_flag) else $error("flag on wrong state"); // RL7

  // an illegal decade state is legal again after two counts
  property p_illegal;
    @(posedge core_clk_in) disable iff (!rstn_in)
    (DECADE && count_reg >= 4'ha && count_en && clear_idle) ##1 (count_en && clear_idle)
      |=> count_reg < 4'ha;
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal state not recovered"); // RL8

  // reset leaves the count at zero
  property p_reset;
    @(posedge core_clk_in)
    !rstn_in |=> count_reg == sfc_pkg::COUNT_RESET;
  endproperty
  a_reset: assert property (p_reset) else $error("reset did not clear count"); // RL1

  // a high flag with the count enabled carries to zero
  property p_carry;
    @(posedge core_clk_in) disable iff (!rstn_in)
    (terminal_count_flag_out && parallel_count_enable_in && load_enable_n_in && clear_idle)
      |=> count_value_out == sfc_pkg::COUNT_RESET;
  endproperty
  a_carry: assert property (p_carry) else $error("flag did not carry to zero"); // RL5 RL6

  // illegal decade states never raise the flag
  property p_flag_illegal;
    @(posedge core_clk_in) disable iff (!rstn_in)
    (DECADE && count_value_out >= sfc_pkg::ILLEGAL_LO) |-> !terminal_count_flag_out;
  endproperty
  a_flag_illegal: assert property (p_flag_illegal) else $error("flag on illegal state"); // RL9

  // illegal decade states follow the fixed recovery walk
  property p_walk;
    @(posedge core_clk_in) disable iff (!rstn_in)
    (DECADE && count_en && clear_idle && count_reg >= sfc_pkg::ILLEGAL_LO)
      |=> ($past(count_reg) == 4'hb && count_reg == 4'h6)
      || ($past(count_reg) == 4'hd && count_reg == 4'h4)
      || ($past(count_reg) == 4'hf && count_reg == 4'h2)
      || (!$past(count_reg[0]) && count_reg == $past(count_reg) + 4'h1);
  endproperty
  a_walk: assert property (p_walk) else $error("illegal state took wrong step"); // RL18

  // binary counting steps by one and wraps at sixteen
  property p_bin_inc;
    @(posedge core_clk_in) disable iff (!rstn_in)
    (!DECADE && count_en && clear_idle) |=> count_reg == $past(count_reg) + 4'h1;
  endproperty
  a_bin_inc: assert property (p_bin_inc) else $error("binary step wrong"); // RL4

  // synchronised clear pin empties the count flops
  property p_aclr_reg;
    @(posedge core_clk_in) disable iff (!rstn_in)
    (ASYNC_CLEAR && !clear_sync) |=> count_reg == sfc_pkg::COUNT_RESET;
  endproperty
  a_aclr_reg: assert property (p_aclr_reg) else $error("count flops not cleared"); // RL14

  // decade counting never leaves the legal range
  property p_decade_range;
    @(posedge core_clk_in) disable iff (!rstn_in)
    (DECADE && count_en && clear_idle && count_reg <= sfc_pkg::DECADE_LAST)
      |=> count_reg <= sfc_pkg::DECADE_LAST;
  endproperty
  a_decade_range: assert property (p_decade_range) else $error("decade count left range"); // RL3

  // load wins over active count enables
  property p_load_wins;
    @(posedge core_clk_in) disable iff (!rstn_in)
    (!load_enable_n_in && parallel_count_enable_in && trickle_count_enable_in && clear_idle)
      |=> count_reg == $past(preload_value_in);
  endproperty
  a_load_wins: assert property (p_load_wins) else $error("count beat load"); // RL11
endmodule

// [rtl/sfc_pkg.sv]
// shared constants for the synchronous four-bit counter
package sfc_pkg;
  localparam int COUNT_WIDTH = 4;
  localparam logic [3:0] COUNT_RESET = 4'h0;
  localparam logic [3:0] DECADE_LAST = 4'h9;
  localparam logic [3:0] BINARY_LAST = 4'hf;
  localparam logic [4:0] DECADE_MOD = 5'h0a;
  localparam logic [4:0] BINARY_MOD = 5'h10;
  localparam logic [3:0] ILLEGAL_LO = 4'ha;
  localparam int SYNC_STAGES = 2;
endpackage

// [rtl/sfc_sync2.sv]
// two-flop synchroniser for one asynchronous level
`timescale 1ns/1ns
module sfc_sync2 #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic core_clk_in, // core clock
  input wire logic rstn_in, // synchronous reset, active low
  input wire logic async_in, // level from outside the domain
  output logic sync_out // synchronised level
);
  logic meta_reg;
  logic sync_reg;

  // first stage feeds only the second
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      meta_reg <= RESET_VAL;
      sync_reg <= RESET_VAL;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule

// [verification/sfc_ctl_model.sv]
// control-side model owning both clear pins of the counter
`timescale 1ns/1ns
module sfc_ctl_model (
  input wire logic clr_req_in, // clear asked for
  output logic async_clear_n_out, // async clear pin
  output logic sync_clear_n_out // sync clear pin
);
  // clear pins never float, held high unless a clear is asked for
  assign async_clear_n_out = !clr_req_in;
  assign sync_clear_n_out = !clr_req_in;
endmodule

// [verification/testbench.sv]
// self-checking bench: decade stage with async clear chained into a binary stage with sync clear
`timescale 1ns/1ns
module testbench;
  logic clk = 1'b0, rstn = 1'b0, ld_n = 1'b1, parallel_count_enable = 1'b0, trickle_count_enable = 1'b0, clr = 1'b0;
  logic [3:0] pv = 4'h0, m = 4'h0, mb = 4'h0, cnt, cnt_b;
  logic flg, flg_b, an, sn;
  logic [9:0] q[$];
  int error_cnt = 0, check_count = 0, cyc = 0;
  sfc_ctl_model ctl_u (.clr_req_in(clr), .async_clear_n_out(an), .sync_clear_n_out(sn));
  sfc_counter dut_u (.core_clk_in(clk), .rstn_in(rstn), .load_enable_n_in(ld_n),
    .parallel_count_enable_in(parallel_count_enable), .trickle_count_enable_in(trickle_count_enable), .async_clear_n_in(an),
    .sync_clear_n_in(sn), .preload_value_in(pv), .count_value_out(cnt),
    .terminal_count_flag_out(flg));
  // binary stage with synchronous clear, chained on the decade flag
  sfc_counter #(.DECADE(1'b0), .ASYNC_CLEAR(1'b0)) hi_u (.core_clk_in(clk), .rstn_in(rstn),
    .load_enable_n_in(ld_n), .parallel_count_enable_in(parallel_count_enable), .trickle_count_enable_in(flg),
    .async_clear_n_in(1'b1), .sync_clear_n_in(sn), .preload_value_in(pv), .count_value_out(cnt_b),
    .terminal_count_flag_out(flg_b));
  // free-running clock
  initial forever #10 clk = ~clk;
  // decade successor, illegal states included
  function automatic logic [3:0] nxt(input logic [3:0] v);
    case (v)
      4'h9: return 4'h0;
      4'hb: return 4'h6;
      4'hd: return 4'h4;
      4'hf: return 4'h2;
      default: return v + 4'h1;
    endcase
  endfunction
  task automatic chk(input logic ok, input string s);
    check_count++;
    if (!ok) begin
      error_cnt++;
      $display("ERROR %0t %s", $time, s);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // drive one cycle at the falling edge and note the expected outcome
  task automatic step(input logic c, l, p, t, input logic [3:0] v);
    @(negedge clk);
    clr = c;
    ld_n = l;
    parallel_count_enable = p;
    trickle_count_enable = t;
    pv = v;
    #1;
    chk(cnt === (c ? 4'h0 : m), "count moved off edge");
    chk(cnt_b === mb, "binary count moved off edge");
    if (c) mb = 4'h0;
    else if (!l) mb = v;
    else if (p && t && m == 4'h9) mb = mb + 4'h1;
    if (c) m = 4'h0;
    else if (!l) m = v;
    else if (p && t) m = nxt(m);
    q.push_back({t && m == 4'h9 && mb == 4'hf, mb, t && m == 4'h9, m});
  endtask
  // watcher compares each edge's outcome with the oldest note
  always @(posedge clk) begin
    #1;
    if (q.size() > 0) chk(q.pop_front() === {flg_b, cnt_b, flg, cnt}, "count or flag");
    cyc++;
    if (cyc > 1000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial begin
    int i;
    void'($urandom(34601));
    repeat (12) @(posedge clk);
    @(negedge clk) rstn = 1'b1;
    // load every value with random enables, then count twice
    for (i = 0; i < 16; i++) begin
      step(1'b0, 1'b0, 1'($urandom), 1'($urandom), i[3:0]);
      step(1'b0, 1'b1, 1'b1, 1'b1, 4'h0);
      step(1'b0, 1'b1, 1'b1, 1'b1, 4'h0);
    end
    $display("test load_and_count done");
    // from fifteen, a lap through nine carries the binary stage round to zero
    step(1'b0, 1'b0, 1'b1, 1'b1, 4'hf);
    repeat (12) step(1'b0, 1'b1, 1'b1, 1'b1, 4'h0);
    $display("test lap done");
    // random mix of load, count and hold
    repeat (150) step(1'b0, 1'($urandom % 4 != 0), 1'($urandom), 1'($urandom), 4'($urandom));
    $display("test random done");
    // clear mid-count overrides a load, then recovers
    step(1'b0, 1'b0, 1'b1, 1'b1, 4'h7);
    repeat (4) step(1'b1, 1'b0, 1'b1, 1'b1, 4'h5);
    repeat (3) step(1'b0, 1'b1, 1'b0, 1'b0, 4'h0);
    step(1'b0, 1'b1, 1'b1, 1'b1, 4'h0);
    step(1'b0, 1'b1, 1'b0, 1'b1, 4'h0);
    $display("test clear done");
    repeat (2) @(posedge clk);
    tally_and_finish();
  end
endmodule
